/* File: cg_defines.svh */
// register map, field positions, reset values and timing counts of the clock generator
`ifndef CG_DEFINES_SVH
`define CG_DEFINES_SVH
`define CG_OFF_CTRL1      8'h00
`define CG_OFF_CTRL2      8'h04
`define CG_OFF_STAT1      8'h08
`define CG_OFF_STAT2      8'h0C
`define CG_OFF_FILT       8'h10
`define CG_OFF_TRIM       8'h14
`define CG_C1_HGO         7
`define CG_C1_RANGE       6
`define CG_C1_REFERENCE_SELECT        5
`define CG_C1_MODE_HI     4
`define CG_C1_MODE_LO     3
`define CG_C1_OSCILLATOR_STOP_ENABLE     2
`define CG_C1_LOSS_OF_CLOCK_DETECT_DISABLE        1
`define CG_C2_LOSS_OF_LOCK_RESET_ENABLE       7
`define CG_C2_MULT_HI     6
`define CG_C2_MULT_LO     4
`define CG_C2_LOSS_OF_CLOCK_RESET_ENABLE       3
`define CG_C2_RED_HI      2
`define CG_C2_RED_LO      0
`define CG_S1_MODE_HI     7
`define CG_S1_MODE_LO     6
`define CG_S1_LOCK        3
`define CG_S1_LOL         2
`define CG_S1_LOC         1
`define CG_S1_IRQF        0
`define CG_S2_STABLE      0
`define CG_CTRL1_RST      8'h00
`define CG_CTRL2_RST      8'h00
`define CG_FILT_RST       12'h000
`define CG_TRIM_RST       8'h80
`define CG_FILT_W         12
`define CG_MODE_SETTLE    4'h8
`define CG_FEI_PRE        4'h7
`define CG_RESP_OKAY      2'b00
`define CG_RESP_SLVERR    2'b10
`endif

/* File: cg_pkg.sv */
// types of the clock generator
package cg_pkg;
    typedef enum logic [3:0] {
        CG_SCM = 4'b0001,
        CG_FEI = 4'b0010,
        CG_FBE = 4'b0100,
        CG_FEE = 4'b1000
    } cg_state_t;
    typedef logic [1:0] cg_mode_code_t;
endpackage

/* File: cg_clock_generator.sv */
// clock generator mode control, divider selection and register slave
// How it works
// RULE1: self-clocked: reference generator off, oscillator open loop, out = osc / R
// RULE2: bypassed external: reference generator and oscillator off, out = ext / R
// RULE3: engaged internal: both run, out = ref / 7 * 64 * N / R
// RULE4: engaged external: out = ext * P * N / R, P 64 or 1 by range
// RULE5: multiplication codes 000..111 give N = 4,6,..,18
// RULE6: reduction codes 000..111 give R = 1,2,4,..,128
// RULE7: control one holds gain, range, refsel, mode, stop enable, detect disable, bit0 zero
// RULE8: mode request 11 selects engaged external
// RULE9: reference select 1 requests the crystal oscillator
// RULE10: high gain 0 selects low-power oscillator
// RULE11: control two holds lock reset enable, N field, clock reset enable, R field
// RULE12: lock reset enable 0 turns loss of lock into an interrupt
// RULE13: clock reset enable 0 turns loss of clock into an interrupt
// RULE14: status one is read-only except writing to clear the interrupt flag
// RULE15: software checks oscillator stable before time-critical work
// RULE16: filter bits 15:12 read zero; loop adjusts it, writes only in self-clocked
// RULE17: software writes trim only when trimming the internal oscillator
// RULE18: after reset the generator is in self-clocked mode
// RULE19: software keeps N and R small for power and jitter
// RULE20: mode codes 00 self, 01 int, 10 bypass, 11 ext; actual mode in status
// RULE21: actual mode follows a request only after several cycles
// RULE22: fixed-frequency clock off in engaged internal and self-clocked modes
// RULE23: divider and mode mux change together only at a settled boundary
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`include "cg_defines.svh"
module cg_clock_generator #(
    parameter int ADDR_W = 8
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire logic                osc_stable,
    input  wire logic                ext_ref_ok,
    input  wire logic                fll_lock,
    input  wire logic                lol_event,
    input  wire logic                loc_event,
    input  wire logic [11:0]         loop_filter_in,
    input  wire logic                loop_filter_upd,
    output logic                     irg_enable,
    output logic                     dco_enable,
    output logic                     osc_enable,
    output logic                     high_gain,
    output logic                     range_high,
    output logic                     loop_closed,
    output logic                     use_ext_ref,
    output logic                     ref_div7,
    output logic                     prescale_64,
    output logic [4:0]               mult_n,
    output logic [7:0]               div_r,
    output logic                     fixed_clk_enable,
    output logic [11:0]              filter_value,
    output logic [7:0]               trim_value,
    output cg_pkg::cg_mode_code_t    clock_mode_actual,
    output logic                     irq,
    output logic                     reset_req
);
    import cg_pkg::*;

    initial begin
        if (ADDR_W < 5 || ADDR_W > 32) begin
            $error("ADDR_W must be 5..32");
        end
    end
    function automatic logic [4:0] decode_n(input logic [2:0] c);
        decode_n = {1'b0, c, 1'b0} + 5'h04; // RULE5
    endfunction
    function automatic logic [7:0] decode_r(input logic [2:0] c);
        decode_r = 8'h01 << c; // RULE6
    endfunction
    function automatic cg_mode_code_t state_code(input cg_state_t s);
        state_code = {s[2] || s[3], s[1] || s[3]}; // RULE20
    endfunction
    logic [7:0]   ctrl1_q;
    logic [7:0]   ctrl2_q;
    logic [11:0]  filt_q;
    logic [7:0]   trim_q;
    logic         hgo_done_q;
    logic         lol_q;
    logic         loc_q;
    logic         irqf_q;
    cg_state_t    state_q;
    cg_state_t    target;
    logic [3:0]   settle_q;
    logic [5:0]   applied_q;
    logic         pending;

    // write channel capture, either order
    logic              aw_full_q;
    logic              w_full_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              do_wr;
    logic [7:0]        wofs;
    logic              wr_hit;

    assign awready = !aw_full_q && !bvalid;
    assign wready  = !w_full_q && !bvalid;
    assign do_wr   = aw_full_q && w_full_q;
    assign wofs    = 8'(waddr_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_full_q <= 1'b0;
            waddr_q   <= '0;
        end else if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            waddr_q   <= awaddr;
        end else if (do_wr) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_full_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (wvalid && wready) begin
            w_full_q <= 1'b1;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
        end else if (do_wr) begin
            w_full_q <= 1'b0;
        end
    end

    // only page zero is mapped, whatever the address width
    assign wr_hit = ((waddr_q >> 8) == '0) && (wofs inside {`CG_OFF_CTRL1, `CG_OFF_CTRL2,
        `CG_OFF_STAT1, `CG_OFF_STAT2, `CG_OFF_FILT, `CG_OFF_TRIM});

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= `CG_RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? `CG_RESP_OKAY : `CG_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    logic wr_c1;
    logic wr_c2;
    logic wr_s1;
    logic wr_flt;
    logic wr_trm;
    assign wr_c1  = do_wr && wr_hit && wofs == `CG_OFF_CTRL1 && wstrb_q[0];
    assign wr_c2  = do_wr && wr_hit && wofs == `CG_OFF_CTRL2 && wstrb_q[0];
    assign wr_s1  = do_wr && wr_hit && wofs == `CG_OFF_STAT1 && wstrb_q[0];
    assign wr_flt = do_wr && wr_hit && wofs == `CG_OFF_FILT;
    assign wr_trm = do_wr && wr_hit && wofs == `CG_OFF_TRIM && wstrb_q[0];
    // gain select sticks after its first write so a running crystal is not upset
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl1_q    <= `CG_CTRL1_RST; // RULE18
            hgo_done_q <= 1'b0;
        end else if (wr_c1) begin
            ctrl1_q[7:1] <= wdata_q[7:1]; // RULE7
            ctrl1_q[0]   <= 1'b0; // RULE7
            hgo_done_q   <= 1'b1;
            if (hgo_done_q) begin
                ctrl1_q[`CG_C1_HGO] <= ctrl1_q[`CG_C1_HGO];
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl2_q <= `CG_CTRL2_RST;
        end else if (wr_c2) begin
            ctrl2_q <= wdata_q[7:0]; // RULE11
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            trim_q <= `CG_TRIM_RST;
        end else if (wr_trm) begin
            trim_q <= wdata_q[7:0];
        end
    end
    // software value only counts in self-clocked mode
    always_ff @(posedge clk) begin
        if (rst) begin
            filt_q <= `CG_FILT_RST;
        end else if (wr_flt && state_q == CG_SCM) begin // RULE16
            if (wstrb_q[0]) begin
                filt_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
                filt_q[11:8] <= wdata_q[11:8];
            end
        end else if (loop_filter_upd && state_q != CG_SCM) begin // RULE16
            filt_q <= loop_filter_in;
        end
    end

    // loss events: interrupt or reset request; set wins over clear
    logic lol_irq;
    logic loc_irq;
    logic loc_seen;
    assign loc_seen = loc_event && !ctrl1_q[`CG_C1_LOSS_OF_CLOCK_DETECT_DISABLE];
    assign lol_irq  = lol_event && !ctrl2_q[`CG_C2_LOSS_OF_LOCK_RESET_ENABLE]; // RULE12
    assign loc_irq  = loc_seen && !ctrl2_q[`CG_C2_LOSS_OF_CLOCK_RESET_ENABLE]; // RULE13

    always_ff @(posedge clk) begin
        if (rst) begin
            lol_q  <= 1'b0;
            loc_q  <= 1'b0;
            irqf_q <= 1'b0;
        end else begin
            if (lol_event) begin
                lol_q <= 1'b1;
            end else if (wr_s1 && wdata_q[`CG_S1_IRQF]) begin // RULE14
                lol_q <= 1'b0;
            end
            if (loc_seen) begin
                loc_q <= 1'b1;
            end else if (wr_s1 && wdata_q[`CG_S1_IRQF]) begin
                loc_q <= 1'b0;
            end
            if (lol_irq || loc_irq) begin
                irqf_q <= 1'b1;
            end else if (wr_s1 && wdata_q[`CG_S1_IRQF]) begin // RULE14
                irqf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reset_req <= 1'b0;
        end else begin
            reset_req <= (lol_event && ctrl2_q[`CG_C2_LOSS_OF_LOCK_RESET_ENABLE])
                      || (loc_seen && ctrl2_q[`CG_C2_LOSS_OF_CLOCK_RESET_ENABLE]); // RULE12 RULE13
        end
    end

    assign irq = irqf_q;

    // target mode: a request is honoured only once its clocks are good
    cg_mode_code_t req;
    assign req = ctrl1_q[`CG_C1_MODE_HI:`CG_C1_MODE_LO];

    always_comb begin
        target = state_q;
        unique case (req)
            2'b00: target = CG_SCM; // RULE1
            2'b01: begin
                if (osc_stable) begin
                    target = CG_FEI; // RULE3
                end
            end
            2'b10: begin
                if (ext_ref_ok) begin
                    target = CG_FBE; // RULE2
                end
            end
            2'b11: begin
                if (ext_ref_ok && osc_stable) begin
                    target = CG_FEE; // RULE8
                end
            end
        endcase
        if ((state_q == CG_FBE || state_q == CG_FEE) && !ext_ref_ok) begin
            target = CG_SCM;
        end
    end

    // divider changes ride the same settle window as mode changes
    assign pending = (target != state_q) || (ctrl2_q[6:4] != applied_q[5:3])
                  || (ctrl2_q[2:0] != applied_q[2:0]);

    always_ff @(posedge clk) begin
        if (rst) begin
            settle_q <= '0;
        end else if (!pending || settle_q == `CG_MODE_SETTLE - 4'h1) begin
            settle_q <= '0;
        end else begin
            settle_q <= settle_q + 4'h1; // RULE21
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q   <= CG_SCM; // RULE18
            applied_q <= {3'(`CG_CTRL2_RST >> `CG_C2_MULT_LO), 3'(`CG_CTRL2_RST)};
        end else if (pending && settle_q == `CG_MODE_SETTLE - 4'h1) begin
            state_q   <= target; // RULE21 RULE23
            applied_q <= {ctrl2_q[6:4], ctrl2_q[2:0]}; // RULE23
        end
    end

    // source controls, all registered so the mux never sees a mixed setting
    always_ff @(posedge clk) begin
        if (rst) begin
            irg_enable       <= 1'b0;
            dco_enable       <= 1'b1;
            loop_closed      <= 1'b0;
            use_ext_ref      <= 1'b0;
            ref_div7         <= 1'b0;
            prescale_64      <= 1'b0;
            fixed_clk_enable <= 1'b0;
        end else begin
            irg_enable       <= state_q == CG_FEI; // RULE1 RULE2 RULE3
            dco_enable       <= state_q != CG_FBE; // RULE1 RULE2
            loop_closed      <= state_q == CG_FEI || state_q == CG_FEE;
            use_ext_ref      <= state_q == CG_FBE || state_q == CG_FEE;
            ref_div7         <= state_q == CG_FEI; // RULE3
            prescale_64      <= state_q == CG_FEI
                             || (state_q == CG_FEE && !ctrl1_q[`CG_C1_RANGE]); // RULE4
            fixed_clk_enable <= state_q == CG_FBE || state_q == CG_FEE; // RULE22
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mult_n <= decode_n(3'(`CG_CTRL2_RST >> `CG_C2_MULT_LO));
            div_r  <= decode_r(3'(`CG_CTRL2_RST));
        end else begin
            mult_n <= decode_n(applied_q[5:3]); // RULE3 RULE4
            div_r  <= decode_r(applied_q[2:0]); // RULE1 RULE2
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            osc_enable <= 1'b0;
            high_gain  <= 1'b0;
            range_high <= 1'b0;
        end else begin
            osc_enable <= ctrl1_q[`CG_C1_REFERENCE_SELECT] && (req[1] || use_ext_ref); // RULE9
            high_gain  <= ctrl1_q[`CG_C1_HGO] && ctrl1_q[`CG_C1_REFERENCE_SELECT]; // RULE10
            range_high <= ctrl1_q[`CG_C1_RANGE];
        end
    end

    assign filter_value      = filt_q;
    assign trim_value        = trim_q;
    assign clock_mode_actual = state_code(state_q); // RULE20

    // read channel
    logic [31:0] rd_mux;
    logic        rd_hit;
    logic [7:0]  rofs;
    assign rofs    = 8'(araddr);
    assign arready = !rvalid;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = (araddr >> 8) == '0;
        unique case (rofs)
            `CG_OFF_CTRL1: rd_mux[7:0] = ctrl1_q;
            `CG_OFF_CTRL2: rd_mux[7:0] = ctrl2_q;
            `CG_OFF_STAT1: rd_mux[7:0] = {state_code(state_q), 2'b00, fll_lock,
                                          lol_q, loc_q, irqf_q};
            `CG_OFF_STAT2: rd_mux[`CG_S2_STABLE] = osc_stable; // RULE15
            `CG_OFF_FILT:  rd_mux[`CG_FILT_W-1:0] = filt_q; // RULE16
            `CG_OFF_TRIM:  rd_mux[7:0] = trim_q;
            default:       rd_hit = 1'b0;
        endcase
        if (!rd_hit) begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `CG_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_mux;
            rresp  <= rd_hit ? `CG_RESP_OKAY : `CG_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

/* File: cg_checker.sv */
// concurrent checks on the clock generator ports
module cg_checker (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  lol_event,
    input wire logic                  loc_event,
    input wire logic                  irg_enable,
    input wire logic                  dco_enable,
    input wire logic                  loop_closed,
    input wire logic                  use_ext_ref,
    input wire logic                  prescale_64,
    input wire logic                  fixed_clk_enable,
    input wire logic                  irq,
    input wire logic [4:0]            mult_n,
    input wire logic [7:0]            div_r,
    input wire cg_pkg::cg_mode_code_t clock_mode_actual
);
    import cg_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // controls lag the mode by one cycle, so only judge a settled mode
    cg_mode_code_t md_q;
    logic          st;
    always_ff @(posedge clk) md_q <= clock_mode_actual;
    assign st = md_q == clock_mode_actual;
    AST_SCM: assert property (st && clock_mode_actual == 2'h0
        |-> !irg_enable && dco_enable && !loop_closed) else $error("self-clocked controls");
    AST_FBE: assert property (st && clock_mode_actual == 2'h2
        |-> !irg_enable && !dco_enable && use_ext_ref && !loop_closed) else $error("bypass controls");
    AST_FEI: assert property (st && clock_mode_actual == 2'h1
        |-> irg_enable && dco_enable && loop_closed && prescale_64) else $error("internal controls");
    AST_FEE: assert property (st && clock_mode_actual == 2'h3
        |-> !irg_enable && use_ext_ref && loop_closed) else $error("external controls");
    AST_FIX: assert property (st
        |-> fixed_clk_enable == clock_mode_actual[1]) else $error("fixed clock enable");
    AST_SETTLE: assert property ($changed(clock_mode_actual)
        |-> $past(clock_mode_actual, 8) == $past(clock_mode_actual)) else $error("mode too fast");
    AST_GLITCH: assert property ($changed(div_r) || $changed(mult_n)
        |-> $past(div_r, 8) == $past(div_r, 2) && $past(mult_n, 8) == $past(mult_n, 2))
        else $error("divider changed early");
    AST_DEC: assert property (mult_n >= 5'h04 && mult_n <= 5'h12 && !mult_n[0]
        && $onehot(div_r)) else $error("factor out of set");
    AST_IRQ: assert property ($rose(irq)
        |-> $past(lol_event || loc_event)) else $error("irq without event");
    AST_RST: assert property ($fell(rst) |-> clock_mode_actual == 2'h0)
        else $error("not self-clocked after reset");
endmodule
bind cg_clock_generator cg_checker i_chk (.clk, .rst, .lol_event, .loc_event, .irg_enable,
    .dco_enable, .loop_closed, .use_ext_ref, .prescale_64, .fixed_clk_enable, .irq, .mult_n,
    .div_r, .clock_mode_actual);

/* File: cg_partner.sv */
// crystal, oscillator and loop model at the far side of the generator
module cg_partner (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  osc_enable,
    input  wire logic  loop_closed,
    input  wire logic  lol_go,
    input  wire logic  loc_go,
    input  wire logic  upd_go,
    output logic       osc_stable,
    output logic       ext_ref_ok,
    output logic       fll_lock,
    output logic       lol_event,
    output logic       loc_event,
    output logic       loop_filter_upd,
    output logic [11:0] loop_filter_in
);
    logic [4:0] su_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            su_q <= 5'h00;
            osc_stable <= 1'h0;
            ext_ref_ok <= 1'h0;
            fll_lock <= 1'h0;
            lol_event <= 1'h0;
            loc_event <= 1'h0;
            loop_filter_upd <= 1'h0;
            loop_filter_in <= 12'h000;
        end else begin
            // crystal needs a start-up span before it counts as present
            su_q <= !osc_enable ? 5'h00 : (su_q == 5'h14 ? su_q : su_q + 5'h01);
            ext_ref_ok <= su_q == 5'h14;
            osc_stable <= 1'h1;
            fll_lock <= loop_closed;
            lol_event <= lol_go;
            loc_event <= loc_go;
            loop_filter_upd <= upd_go;
            // junk between updates so a stale value cannot pass
            loop_filter_in <= loop_filter_in + 12'h5A3;
        end
    end
endmodule

/* File: tb.sv */
// self-checking bench for the clock generator
`include "cg_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cg_pkg::*;
    logic clk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, lol_go = 1'h0, loc_go = 1'h0, upd_go = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, div_r, trim_value, tv;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, r, pm;
    logic awready, wready, bvalid, arready, rvalid, osc_stable, ext_ref_ok, fll_lock;
    logic lol_event, loc_event, loop_filter_upd, irg_enable, dco_enable, osc_enable;
    logic high_gain, range_high, loop_closed, use_ext_ref, ref_div7, prescale_64;
    logic fixed_clk_enable, irq, reset_req;
    logic [4:0] mult_n;
    logic [11:0] loop_filter_in, filter_value, f_seen, fexp;
    logic [2:0] c;
    cg_mode_code_t clock_mode_actual;
    int err_total = 0, n_checks = 0, seed = 11, rq_n = 0;
    initial forever #12.5 clk = ~clk;
    cg_clock_generator i_dut (.*);
    cg_partner i_far (.*);
    always @(posedge clk) begin
        if (loop_filter_upd === 1'h1) f_seen <= loop_filter_in;
        if (reset_req === 1'h1) rq_n <= rq_n + 1;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, ok;
        int t;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        t = 0;
        do begin
            #1;
            ta = awvalid && awready;
            tw = wvalid && wready;
            ok = bvalid === 1'h1;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            t++;
        end while (!ok && t < 60);
        bready <= 1'h0;
        if (!ok) chk("bvalid", 1, 0);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, ok;
        int t;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        t = 0;
        do begin
            #1;
            ta = arvalid && arready;
            ok = rvalid === 1'h1;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'h0;
            t++;
        end while (!ok && t < 60);
        rready <= 1'h0;
        if (!ok) chk("rvalid", 1, 0);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a);
        chk(n, e, d);
    endtask
    // one-cycle loss pulse from the far side, then let the flag land
    task automatic ev(input logic lol);
        @(posedge clk);
        lol_go <= lol;
        loc_go <= !lol;
        @(posedge clk);
        lol_go <= 1'h0;
        loc_go <= 1'h0;
        repeat (4) @(posedge clk);
    endtask
    // irg, dco, closed, prescale 64, fixed clock, external ref
    function automatic logic [5:0] ctl(input logic [1:0] m, input logic g);
        case (m)
            2'h0: return 6'h10;
            2'h1: return 6'h3C;
            2'h2: return 6'h03;
            default: return {3'h3, !g, 2'h3};
        endcase
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #(25 * 40000);
        chk("timeout", 0, 1);
        close_out;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rc(`CG_OFF_CTRL1, 0, "ctrl1");
        rc(`CG_OFF_CTRL2, 0, "ctrl2");
        rc(`CG_OFF_TRIM, 32'h80, "trim");
        rc(`CG_OFF_FILT, 0, "filt");
        rd(`CG_OFF_STAT1);
        chk("stat1", 0, d & 32'hC7);
        rc(`CG_OFF_STAT2, {31'h0, osc_stable}, "stat2");
        for (int i = 0; i < 8; i++) begin
            c = $random(seed);
            wr(`CG_OFF_CTRL2, {25'h0, 3'(i), 1'h0, c});
            repeat (12) @(posedge clk);
            #1;
            chk("mult_n", 4 + 2 * i, mult_n);
            chk("div_r", 32'h1 << c, div_r);
            rc(`CG_OFF_CTRL2, {25'h0, 3'(i), 1'h0, c}, "ctrl2");
        end
        tv = $random(seed);
        wr(`CG_OFF_TRIM, {24'h0, tv});
        chk("trim_value", tv, trim_value);
        wr(8'h20, 32'hFFFFFFFF);
        chk("bresp", `CG_RESP_SLVERR, r);
        rd(8'h20);
        chk("rresp", `CG_RESP_SLVERR, r);
        chk("rdata", 0, d);
        wr(`CG_OFF_CTRL1, 32'h79);
        rc(`CG_OFF_CTRL1, 32'h78, "ctrl1");
        chk("high_gain", 0, high_gain);
        chk("osc_enable", 1, osc_enable);
        repeat (50) @(posedge clk);
        #1;
        chk("mode fee", 3, clock_mode_actual);
        pm = 2'h3;
        for (int i = 0; i < 8; i++) begin
            wr(`CG_OFF_CTRL1, {25'h0, i[2], 1'h1, i[1:0], 3'h0});
            #1;
            chk("mode early", pm, clock_mode_actual);
            repeat (50) @(posedge clk);
            #1;
            chk("mode", i[1:0], clock_mode_actual);
            chk("ctl", ctl(i[1:0], i[2]), {irg_enable, dco_enable, loop_closed, prescale_64,
                fixed_clk_enable, use_ext_ref});
            chk("ref_div7", i[1:0] == 2'h1, ref_div7);
            chk("range_high", i[2], range_high);
            pm = i[1:0];
            if (i[1:0] == 2'h0) begin
                fexp = $random(seed);
                wr(`CG_OFF_FILT, {16'h0, 4'hF, fexp});
                rc(`CG_OFF_FILT, fexp, "filt");
            end
            if (i[1:0] == 2'h1) begin
                wr(`CG_OFF_FILT, 32'hABC);
                rc(`CG_OFF_FILT, fexp, "filt held");
                upd_go <= 1'h1;
                @(posedge clk);
                upd_go <= 1'h0;
                repeat (3) @(posedge clk);
                rc(`CG_OFF_FILT, f_seen, "filt loop");
                chk("filter_value", f_seen, filter_value);
            end
        end
        wr(`CG_OFF_CTRL2, 32'h30);
        ev(1'h1);
        chk("irq lol", 1, irq);
        chk("req", 0, rq_n);
        rc(`CG_OFF_STAT1, 32'hCD, "stat1 lol");
        wr(`CG_OFF_STAT1, 32'hFF);
        rd(`CG_OFF_STAT1);
        chk("stat1 clr", 32'hC0, d & 32'hC7);
        chk("irq clr", 0, irq);
        ev(1'h0);
        chk("irq loc", 1, irq);
        rd(`CG_OFF_STAT1);
        chk("stat1 loc", 32'hC3, d & 32'hC7);
        wr(`CG_OFF_STAT1, 32'h01);
        wr(`CG_OFF_CTRL2, 32'hB0);
        ev(1'h1);
        chk("req", 1, rq_n);
        chk("irq", 0, irq);
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        chk("mode rst", 0, clock_mode_actual);
        rc(`CG_OFF_CTRL1, 0, "ctrl1 rst");
        close_out;
    end
endmodule
